// >>> hw/acd_pkg.sv
// Constants, types and register map for the command dispatch block.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port.
package acd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BSY_MAX_NS = 400;
  localparam int unsigned DRQ_PIO_OUT_NS = 700;
  localparam int unsigned BSY_MAX_CYC = (BSY_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned DRQ_PIO_OUT_CYC = (DRQ_PIO_OUT_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_FEATURE = 6'h04;
  localparam logic [5:0] OFF_SECCNT = 6'h08;
  localparam logic [5:0] OFF_SECNUM = 6'h0c;
  localparam logic [5:0] OFF_CYL_LO = 6'h10;
  localparam logic [5:0] OFF_CYL_HI = 6'h14;
  localparam logic [5:0] OFF_DEVHEAD = 6'h18;
  localparam logic [5:0] OFF_CMD_STAT = 6'h1c;
  localparam logic [5:0] OFF_ERROR = 6'h20;
  localparam logic [5:0] OFF_ALT_STAT = 6'h24;
  localparam logic [5:0] OFF_CONFIG = 6'h28;
  localparam logic [5:0] OFF_CONTROL = 6'h2c;
  localparam logic [5:0] OFF_DECODE = 6'h30;
  localparam logic [5:0] OFF_DOOR = 6'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_DRDY = 6;
  localparam int unsigned ST_DRQ = 3;
  localparam int unsigned ST_ERR = 0;
  localparam int unsigned ER_MCR = 3;
  localparam int unsigned ER_ABRT = 2;
  localparam int unsigned DH_DEV = 4;
  localparam int unsigned CF_PM_SUP = 0;
  localparam int unsigned CF_LOCK_CAP = 1;
  localparam int unsigned CF_READY = 2;
  localparam int unsigned CF_DEV_ID = 3;
  localparam int unsigned CT_FINISH = 0;
  localparam int unsigned CT_FAIL = 1;
  localparam int unsigned VM_FR = 4;
  localparam int unsigned VM_SC = 3;
  localparam int unsigned VM_SN = 2;
  localparam int unsigned VM_CY = 1;
  localparam int unsigned VM_DH = 0;

  // ----------------------------------------------------------------
  // Reset values and diagnostic pass code
  // ----------------------------------------------------------------
  localparam logic [3:0] CONFIG_RST = 4'h7;
  localparam logic [7:0] SECCNT_RST = 8'h01;
  localparam logic [7:0] SECNUM_RST = 8'h01;
  localparam logic [7:0] ERROR_RST = 8'h01;
  localparam logic [7:0] DIAG_PASS = 8'h01;

  // ----------------------------------------------------------------
  // Protocol classes and power modes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLS_NON_DATA = 3'h0;
  localparam logic [2:0] CLS_PIO_IN = 3'h1;
  localparam logic [2:0] CLS_PIO_OUT = 3'h2;
  localparam logic [2:0] CLS_DMA = 3'h3;
  localparam logic [2:0] CLS_VENDOR = 3'h4;
  localparam logic [2:0] CLS_RESERVED = 3'h5;
  localparam logic [1:0] PM_ACTIVE = 2'h0;
  localparam logic [1:0] PM_IDLE = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [7:0] PM_CODE_STANDBY = 8'h00;
  localparam logic [7:0] PM_CODE_IDLE = 8'h80;
  localparam logic [7:0] PM_CODE_ACTIVE = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACD_IDLE, ACD_EXEC, ACD_XFER} acd_state_t;

  typedef struct packed {
    logic [2:0] cls;
    logic [4:0] vmask;
    logic impl;
  } acd_dec_t;

  typedef struct packed {
    acd_state_t st;
    logic [7:0] feature_param_reg;
    logic [7:0] sector_count_param;
    logic [7:0] sector_number_param;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] device_head_param;
    logic [7:0] cmd;
    logic bsy;
    logic drq;
    logic err;
    logic [7:0] err_reg;
    logic intrq;
    logic locked;
    logic mcr_pend;
    logic btn;
    logic [1:0] pmode;
    logic [3:0] cfg;
    logic [2:0] dcls;
    logic [4:0] dvmask;
    logic [3:0] head_used;
    logic ack;
    logic [31:0] rdata;
    logic xfer_start;
    logic eject_pulse;
  } acd_st_t;

endpackage

// >>> hw/acd_dispatch.sv
// Command decode and dispatch front end with door lock and power query.
// Assumes synchronous inputs on clk_sys and an Avalon-MM master that
// holds each request until waitrequest is seen low.
//
// Operation
// - BSY or DRQ within 400 ns
// - PIO-out: BSY clear, DRQ set within 700 ns
// - Accept legacy and preferred power opcodes
// - Implement all mandatory commands
// - 20h/21h decode as PIO-in reads
// - 30h/31h decode as PIO-out writes
// - C8h-CBh decode as DMA commands
// - 40h/41h decode as non-data verify
// - Vendor opcodes flagged; others reserved
// - Use only parameters valid for command
// - Select-only commands ignore head field
// - Diagnostic runs regardless of device select
// - Status valid; error valid when ERR
// - Removable-media opcodes DBh-DDh abort
// - Power query loads 00h/80h/FFh, then INTRQ
// - No power management: query aborts
// - Lock when unlocked, good status
// - Locked: report button via MEDIA_CHANGE_REQUESTED_BIT and ERR
// - Not ready or incapable: ABRT and ERR
// - Locked ignores button; cleared by DFh/EDh/reset
// - DFh unlocks and re-enables button
`timescale 1ns/1ps
`default_nettype none

module acd_dispatch (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Avalon-MM register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Media and host signalling
  input wire logic eject_req_btn,
  output logic intrq,
  output logic door_locked,
  output logic media_eject,
  // Transfer engine hand-off
  output logic xfer_start,
  output logic [2:0] xfer_class,
  output logic [3:0] xfer_head
);

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  function automatic acd_pkg::acd_dec_t decode(input logic [7:0] op);
    acd_pkg::acd_dec_t d;
    d.cls = acd_pkg::CLS_NON_DATA;
    d.vmask = 5'h00;
    d.impl = 1'b0;
    casez (op)
      8'h20, 8'h21: begin
        d.cls = acd_pkg::CLS_PIO_IN;
        d.vmask = 5'h0f;
        d.impl = 1'b1;
      end
      8'h22, 8'h23, 8'hc4: begin
        d.cls = acd_pkg::CLS_PIO_IN;
        d.vmask = 5'h0f;
      end
      8'h30, 8'h31: begin
        d.cls = acd_pkg::CLS_PIO_OUT;
        d.vmask = 5'h0f;
        d.impl = 1'b1;
      end
      8'h32, 8'h33, 8'h3c, 8'hc5: begin
        d.cls = acd_pkg::CLS_PIO_OUT;
        d.vmask = 5'h0f;
      end
      8'hc8, 8'hc9, 8'hca, 8'hcb: begin
        d.cls = acd_pkg::CLS_DMA;
        d.vmask = 5'h0f;
        d.impl = 1'b1;
      end
      8'h40, 8'h41: begin
        d.vmask = 5'h0f;
        d.impl = 1'b1;
      end
      8'h7?: begin
        d.vmask = 5'h07;
        d.impl = 1'b1;
      end
      8'h90, 8'hed, 8'hde, 8'hdf, 8'h94, 8'h95, 8'h99, 8'he0, 8'he1, 8'he6: begin
        d.impl = 1'b1;
      end
      8'h91: begin
        d.vmask = 5'h09;
        d.impl = 1'b1;
      end
      8'h96, 8'h97, 8'h98, 8'he2, 8'he3, 8'he5: begin
        d.vmask = 5'h08;
        d.impl = 1'b1;
      end
      8'hec: begin
        d.cls = acd_pkg::CLS_PIO_IN;
        d.impl = 1'b1;
      end
      8'hee: d.cls = acd_pkg::CLS_DMA;
      8'he4: d.cls = acd_pkg::CLS_PIO_IN;
      8'he8: d.cls = acd_pkg::CLS_PIO_OUT;
      8'h92: begin
        d.cls = acd_pkg::CLS_PIO_OUT;
        d.vmask = 5'h1e;
      end
      8'heb: begin
        d.cls = acd_pkg::CLS_PIO_OUT;
        d.vmask = 5'h18;
      end
      8'hea, 8'hef: d.vmask = 5'h10;
      8'hb0: d.vmask = 5'h12;
      8'hc6: d.vmask = 5'h08;
      8'h00: d.vmask = 5'h01;
      8'h1?: d.vmask = 5'h00;
      8'hdb, 8'hdc, 8'hdd, 8'h50, 8'h9a, 8'b1100_00??, 8'h8?, 8'hf?: begin
        d.cls = acd_pkg::CLS_VENDOR;
      end
      default: d.cls = acd_pkg::CLS_RESERVED;
    endcase
    return d;
  endfunction

  // Completion: status valid, error valid under ERR, interrupt raised.
  function automatic acd_pkg::acd_st_t finish(input acd_pkg::acd_st_t s,
                                               input logic abort);
    acd_pkg::acd_st_t r;
    r = s;
    r.st = acd_pkg::ACD_IDLE;
    r.bsy = 1'b0;
    r.drq = 1'b0;
    r.intrq = 1'b1;
    if (abort) begin
      r.err = 1'b1;
      r.err_reg[acd_pkg::ER_ABRT] = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acd_pkg::acd_st_t q_ff;
  acd_pkg::acd_st_t nxt_q;
  acd_pkg::acd_dec_t dec_cmd;
  acd_pkg::acd_dec_t dec_new;

  assign dec_cmd = decode(q_ff.cmd);
  assign dec_new = decode(avs_writedata[7:0]);

  always_comb begin
    logic acc;
    logic wr;
    logic [7:0] wd;
    logic [31:0] rv;
    logic sel;
    logic cfg_ok;
    acc = 1'b0;
    wr = 1'b0;
    wd = 8'h00;
    rv = 32'h0000_0000;
    sel = 1'b0;
    cfg_ok = 1'b0;
    nxt_q = q_ff;
    nxt_q.xfer_start = 1'b0;
    nxt_q.eject_pulse = 1'b0;

    // ----------------------------------------------------------------
    // Bus slave: one wait state, data registered in the first cycle
    // ----------------------------------------------------------------
    acc = (avs_read | avs_write) & ~q_ff.ack;
    nxt_q.ack = acc;
    unique case (avs_address)
      acd_pkg::OFF_FEATURE: rv[7:0] = q_ff.feature_param_reg;
      acd_pkg::OFF_SECCNT: rv[7:0] = q_ff.sector_count_param;
      acd_pkg::OFF_SECNUM: rv[7:0] = q_ff.sector_number_param;
      acd_pkg::OFF_CYL_LO: rv[7:0] = q_ff.cyl_lo;
      acd_pkg::OFF_CYL_HI: rv[7:0] = q_ff.cyl_hi;
      acd_pkg::OFF_DEVHEAD: rv[7:0] = q_ff.device_head_param;
      acd_pkg::OFF_CMD_STAT, acd_pkg::OFF_ALT_STAT: begin
        rv[acd_pkg::ST_BSY] = q_ff.bsy;
        rv[acd_pkg::ST_DRDY] = q_ff.cfg[acd_pkg::CF_READY] & ~q_ff.bsy;
        rv[acd_pkg::ST_DRQ] = q_ff.drq;
        rv[acd_pkg::ST_ERR] = q_ff.err;
      end
      acd_pkg::OFF_ERROR: rv[7:0] = q_ff.err_reg;
      acd_pkg::OFF_CONFIG: rv[3:0] = q_ff.cfg;
      acd_pkg::OFF_DECODE: rv[11:0] = {q_ff.head_used, q_ff.dcls, q_ff.dvmask};
      acd_pkg::OFF_DOOR: rv[4:0] = {q_ff.pmode, q_ff.btn, q_ff.mcr_pend, q_ff.locked};
      default: rv = 32'h0000_0000;
    endcase
    if (acc && avs_read) begin
      nxt_q.rdata = rv;
    end
    wr = avs_write & q_ff.ack & avs_byteenable[0];
    wd = avs_writedata[7:0];
    // Reading status acknowledges the interrupt; a new one set below wins
    if (avs_read && q_ff.ack && avs_address == acd_pkg::OFF_CMD_STAT) begin
      nxt_q.intrq = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Parameter writes while busy are dropped so a running command
    // keeps the values it was issued with.
    if (wr && !q_ff.bsy && !q_ff.drq) begin
      unique case (avs_address)
        acd_pkg::OFF_FEATURE: nxt_q.feature_param_reg = wd;
        acd_pkg::OFF_SECCNT: nxt_q.sector_count_param = wd;
        acd_pkg::OFF_SECNUM: nxt_q.sector_number_param = wd;
        acd_pkg::OFF_CYL_LO: nxt_q.cyl_lo = wd;
        acd_pkg::OFF_CYL_HI: nxt_q.cyl_hi = wd;
        acd_pkg::OFF_DEVHEAD: nxt_q.device_head_param = wd;
        acd_pkg::OFF_CONFIG: nxt_q.cfg = wd[3:0];
        acd_pkg::OFF_CMD_STAT: begin
          sel = q_ff.device_head_param[acd_pkg::DH_DEV] == q_ff.cfg[acd_pkg::CF_DEV_ID];
          if (sel || wd == 8'h90) begin
            nxt_q.cmd = wd;
            nxt_q.bsy = 1'b1;
            nxt_q.err = 1'b0;
            nxt_q.err_reg = 8'h00;
            nxt_q.intrq = 1'b0;
            nxt_q.dcls = dec_new.cls;
            nxt_q.dvmask = dec_new.vmask;
            nxt_q.st = acd_pkg::ACD_EXEC;
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Command execution
    // ----------------------------------------------------------------
    cfg_ok = q_ff.cfg[acd_pkg::CF_READY] & q_ff.cfg[acd_pkg::CF_LOCK_CAP];
    unique case (q_ff.st)
      acd_pkg::ACD_IDLE: ;
      acd_pkg::ACD_EXEC: begin
        // Head bits pass only where the device/head register is fully valid
        nxt_q.head_used = dec_cmd.vmask[acd_pkg::VM_DH] ?
                          q_ff.device_head_param[3:0] : 4'h0;
        if (!dec_cmd.impl) begin
          nxt_q = finish(nxt_q, 1'b1);
        end else begin
          unique casez (q_ff.cmd)
            8'h98, 8'he5: begin
              if (!q_ff.cfg[acd_pkg::CF_PM_SUP]) begin
                nxt_q = finish(nxt_q, 1'b1);
              end else begin
                unique case (q_ff.pmode)
                  acd_pkg::PM_STANDBY: nxt_q.sector_count_param = acd_pkg::PM_CODE_STANDBY;
                  acd_pkg::PM_IDLE: nxt_q.sector_count_param = acd_pkg::PM_CODE_IDLE;
                  default: nxt_q.sector_count_param = acd_pkg::PM_CODE_ACTIVE;
                endcase
                nxt_q = finish(nxt_q, 1'b0);
              end
            end
            8'h94, 8'h96, 8'h99, 8'he0, 8'he2, 8'he6: begin
              if (q_ff.cfg[acd_pkg::CF_PM_SUP]) begin
                nxt_q.pmode = acd_pkg::PM_STANDBY;
              end
              nxt_q = finish(nxt_q, !q_ff.cfg[acd_pkg::CF_PM_SUP]);
            end
            8'h95, 8'h97, 8'he1, 8'he3: begin
              if (q_ff.cfg[acd_pkg::CF_PM_SUP]) begin
                nxt_q.pmode = acd_pkg::PM_IDLE;
              end
              nxt_q = finish(nxt_q, !q_ff.cfg[acd_pkg::CF_PM_SUP]);
            end
            8'h90: begin
              nxt_q.sector_count_param = acd_pkg::SECCNT_RST;
              nxt_q.sector_number_param = acd_pkg::SECNUM_RST;
              nxt_q.cyl_lo = 8'h00;
              nxt_q.cyl_hi = 8'h00;
              nxt_q.device_head_param = 8'h00;
              nxt_q = finish(nxt_q, 1'b0);
              nxt_q.err_reg = acd_pkg::DIAG_PASS;
            end
            8'hde: begin
              if (!cfg_ok) begin
                nxt_q = finish(nxt_q, 1'b1);
              end else if (!q_ff.locked) begin
                nxt_q.locked = 1'b1;
                nxt_q = finish(nxt_q, 1'b0);
              end else if (eject_req_btn || q_ff.mcr_pend) begin
                nxt_q = finish(nxt_q, 1'b0);
                nxt_q.err = 1'b1;
                nxt_q.err_reg[acd_pkg::ER_MCR] = 1'b1;
                nxt_q.mcr_pend = 1'b0;
              end else begin
                nxt_q = finish(nxt_q, 1'b0);
              end
            end
            8'hdf: begin
              if (cfg_ok) begin
                nxt_q.locked = 1'b0;
                nxt_q.mcr_pend = 1'b0;
              end
              nxt_q = finish(nxt_q, !cfg_ok);
            end
            8'hed: begin
              if (q_ff.cfg[acd_pkg::CF_READY]) begin
                nxt_q.locked = 1'b0;
                nxt_q.mcr_pend = 1'b0;
                nxt_q.eject_pulse = 1'b1;
              end
              nxt_q = finish(nxt_q, !q_ff.cfg[acd_pkg::CF_READY]);
            end
            default: begin
              if (dec_cmd.cls == acd_pkg::CLS_NON_DATA) begin
                nxt_q = finish(nxt_q, 1'b0);
              end else begin
                // Data protocols hand over to the transfer engine
                nxt_q.xfer_start = 1'b1;
                nxt_q.st = acd_pkg::ACD_XFER;
                if (dec_cmd.cls != acd_pkg::CLS_DMA) begin
                  nxt_q.bsy = 1'b0;
                  nxt_q.drq = 1'b1;
                end
                if (dec_cmd.cls == acd_pkg::CLS_PIO_IN) begin
                  nxt_q.intrq = 1'b1;
                end
              end
            end
          endcase
        end
      end
      acd_pkg::ACD_XFER: begin
        if (wr && avs_address == acd_pkg::OFF_CONTROL && wd[acd_pkg::CT_FINISH]) begin
          nxt_q = finish(nxt_q, wd[acd_pkg::CT_FAIL]);
        end
      end
      default: nxt_q.st = acd_pkg::ACD_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Eject button: press while locked only records the request
    // ----------------------------------------------------------------
    if (eject_req_btn && !q_ff.btn) begin
      if (nxt_q.locked) begin
        nxt_q.mcr_pend = 1'b1;
      end else begin
        nxt_q.eject_pulse = 1'b1;
      end
    end
    nxt_q.btn = eject_req_btn;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
      q_ff.st <= acd_pkg::ACD_IDLE;
      q_ff.sector_count_param <= acd_pkg::SECCNT_RST;
      q_ff.sector_number_param <= acd_pkg::SECNUM_RST;
      q_ff.err_reg <= acd_pkg::ERROR_RST;
      q_ff.pmode <= acd_pkg::PM_ACTIVE;
      q_ff.cfg <= acd_pkg::CONFIG_RST;
      q_ff.locked <= 1'b0;
    end else if (clk_en) begin
      q_ff <= nxt_q;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~q_ff.ack;
  assign avs_readdata = q_ff.rdata;
  assign intrq = q_ff.intrq;
  assign door_locked = q_ff.locked;
  assign media_eject = q_ff.eject_pulse;
  assign xfer_start = q_ff.xfer_start;
  assign xfer_class = q_ff.dcls;
  assign xfer_head = q_ff.head_used;

endmodule // acd_dispatch

`default_nettype wire

// >>> tb/acd_dispatch_chk.sv
// Port-level assertions for the command dispatch block.
// Assumes clk_en is low only while no pulse output stands; bound to every acd_dispatch.
`timescale 1ns/1ps
`default_nettype none
module acd_dispatch_chk (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Media and hand-off
  input wire logic eject_req_btn,
  input wire logic intrq,
  input wire logic door_locked,
  input wire logic media_eject,
  input wire logic xfer_start,
  input wire logic [2:0] xfer_class
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rd_done;
  assign rd_done = avs_read && !avs_waitrequest;
  chk_wait_one: assert property (avs_waitrequest && clk_en |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_xfer_cls: assert property (xfer_start |-> xfer_class inside {3'h1, 3'h2, 3'h3})
    else $error("hand-off with non-data class");
  chk_xfer_once: assert property (xfer_start |=> !xfer_start)
    else $error("hand-off pulse too long");
  chk_eject_once: assert property (media_eject |=> !media_eject)
    else $error("eject pulse too long");
  chk_btn_ignored: assert property (door_locked && $rose(eject_req_btn) |=> !media_eject)
    else $error("button ejected locked media");
  chk_lock_hold: assert property (door_locked && !avs_write && !$past(avs_write)
    && !$past(avs_write, 2) |=> door_locked) else $error("lock lost without command");
  chk_intrq_clr: assert property (rd_done && avs_address == 6'h1c |=> !intrq)
    else $error("status read kept interrupt");
  chk_alt_keep: assert property (rd_done && avs_address == 6'h24 && intrq |=> intrq)
    else $error("alternate status read cleared interrupt");
  chk_rdata_hi: assert property (rd_done |-> avs_readdata[31:12] == 20'h0)
    else $error("upper read data not zero");
  cover property (xfer_start && xfer_class == 3'h3);
  cover property (media_eject);
  cover property (door_locked && $rose(eject_req_btn));
endmodule // acd_dispatch_chk
bind acd_dispatch acd_dispatch_chk acd_dispatch_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .eject_req_btn(eject_req_btn), .intrq(intrq), .door_locked(door_locked),
  .media_eject(media_eject), .xfer_start(xfer_start), .xfer_class(xfer_class));
`default_nettype wire

// >>> tb/acd_host.sv
// Host adapter model: Avalon-MM master reaching the command registers.
// Assumes a slave that lowers waitrequest within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module acd_host (
  // Clock
  input wire logic clk_sys,
  // Bus towards the block
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  int tmo = 0;
  initial begin
    avs_address <= 6'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'hf;
  end
  // Request held until waitrequest seen low at a rising edge
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    // Sampled at the rising edge, before that edge's register updates land
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) tmo++;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // acd_host
`default_nettype wire

// >>> tb/tb_acd_dispatch.sv
// Self-checking bench for the command dispatch block.
// Assumes the host model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_acd_dispatch;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic btn = 1'b0;
  logic ce = 1'b1;
  logic [5:0] adr;
  logic rd, wr_s, wt, intrq, lck, ej, xs;
  logic [31:0] wd, rdat;
  logic [3:0] be, hd;
  logic [2:0] cls, c;
  logic [7:0] op, dh, st;
  int err_total = 0;
  int n_tests = 0;
  int nx = 0;
  int ne = 0;
  int n0;
  logic [7:0] ops[22] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'h40,
    8'h41, 8'h91, 8'h75, 8'hec, 8'h9a, 8'hc0, 8'hc3, 8'h85, 8'hf7, 8'hdb, 8'hdc, 8'hdd, 8'h02};
  logic [7:0] pw[10] = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h99, 8'he0, 8'he1, 8'he2, 8'he3, 8'he6};
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (xs === 1'b1) nx <= nx + 1;
    if (ej === 1'b1) ne <= ne + 1;
  end
  acd_host acd_host_inst (.clk_sys(clk_sys), .avs_address(adr), .avs_read(rd),
    .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt));
  acd_dispatch acd_dispatch_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce),
    .avs_address(adr), .avs_read(rd), .avs_write(wr_s), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt), .eject_req_btn(btn),
    .intrq(intrq), .door_locked(lck), .media_eject(ej), .xfer_start(xs), .xfer_class(cls),
    .xfer_head(hd));
  // ----------------------------------------
  // Expectations and bus helpers
  // ----------------------------------------
  function automatic logic [2:0] f_cls(input logic [7:0] o);
    case (o)
      8'h20, 8'h21, 8'hec: return 3'h1;
      8'h30, 8'h31: return 3'h2;
      8'hc8, 8'hc9, 8'hca, 8'hcb: return 3'h3;
      8'h40, 8'h41, 8'h91, 8'h75: return 3'h0;
      8'h02: return 3'h5;
      default: return 3'h4;
    endcase
  endfunction
  function automatic logic f_hd(input logic [7:0] o);
    return f_cls(o) inside {3'h0, 3'h2, 3'h3} || o inside {8'h20, 8'h21};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    acd_host_inst.xfer(w, a, d, q);
    if (acd_host_inst.tmo != 0) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic chk_rd(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    bus(1'b0, a, 8'h00, v);
    check(nm, v, e);
  endtask
  task automatic cmd_st(input logic [7:0] o, input logic [7:0] e);
    wr(6'h1c, o);
    chk_rd("status", 6'h1c, e);
  endtask
  task automatic press(input logic v);
    @(posedge clk_sys);
    btn <= v;
    // Third edge lets the pulse counter settle before it is read
    repeat (3) @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9c0e3843));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk_rd("count", 6'h08, 8'h01);
    chk_rd("error", 6'h20, 8'h01);
    chk_rd("status", 6'h1c, 8'h40);
    check("locked", lck, 1'b0);
    $display("-- reset values done");
    foreach (ops[i]) begin
      op = ops[i];
      c = f_cls(op);
      for (int a = 1; a < 6; a++) wr(6'(a * 4), 8'($urandom));
      dh = 8'($urandom) & 8'hef;
      wr(6'h18, dh);
      n0 = nx;
      wr(6'h1c, op);
      st = (c == 3'h1 || c == 3'h2) ? 8'h48 : (c == 3'h3) ? 8'h80 : (c == 3'h0) ? 8'h40 : 8'h41;
      chk_rd("alt", 6'h24, st);
      check("intrq", intrq, (c inside {3'h2, 3'h3}) ? 1'b0 : 1'b1);
      chk_rd("status", 6'h1c, st);
      check("class", cls, c);
      check("head", hd, f_hd(op) ? dh[3:0] : 4'h0);
      check("start", nx - n0, (c inside {3'h1, 3'h2, 3'h3}) ? 1 : 0);
      if (c > 3'h3) chk_rd("error", 6'h20, 8'h04);
      if (st[7] | st[3]) begin
        wr(6'h2c, {6'h00, i[0], 1'b1});
        chk_rd("done", 6'h1c, i[0] ? 8'h41 : 8'h40);
      end
      $display("-- opcode %h done", op);
    end
    cmd_st(8'he5, 8'h40);
    chk_rd("power", 6'h08, 8'hff);
    foreach (pw[i]) begin
      cmd_st(pw[i], 8'h40);
      wr(6'h1c, i[0] ? 8'h98 : 8'he5);
      chk_rd("power", 6'h08, pw[i] inside {8'h95, 8'h97, 8'he1, 8'he3} ? 8'h80 : 8'h00);
    end
    wr(6'h28, 8'h06);
    cmd_st(8'h98, 8'h41);
    chk_rd("error", 6'h20, 8'h04);
    wr(6'h28, 8'h07);
    $display("-- power query done");
    cmd_st(8'hde, 8'h40);
    check("locked", lck, 1'b1);
    n0 = ne;
    press(1'b1);
    check("eject", ne - n0, 0);
    chk_rd("door", 6'h34, 8'h17);
    cmd_st(8'hde, 8'h41);
    chk_rd("error", 6'h20, 8'h08);
    press(1'b0);
    cmd_st(8'hde, 8'h40);
    cmd_st(8'hdf, 8'h40);
    check("locked", lck, 1'b0);
    press(1'b1);
    check("eject", ne - n0, 1);
    press(1'b0);
    cmd_st(8'hde, 8'h40);
    cmd_st(8'hed, 8'h40);
    check("locked", lck, 1'b0);
    check("eject", ne - n0, 2);
    ce <= 1'b0;
    press(1'b1);
    check("frozen", ne - n0, 2);
    ce <= 1'b1;
    press(1'b0);
    check("eject", ne - n0, 3);
    wr(6'h28, 8'h05);
    cmd_st(8'hde, 8'h41);
    chk_rd("error", 6'h20, 8'h04);
    check("locked", lck, 1'b0);
    wr(6'h28, 8'h07);
    cmd_st(8'hde, 8'h40);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    check("locked", lck, 1'b0);
    $display("-- door lock done");
    wr(6'h08, 8'h55);
    wr(6'h18, 8'h10);
    cmd_st(8'h90, 8'h40);
    chk_rd("error", 6'h20, 8'h01);
    chk_rd("count", 6'h08, 8'h01);
    wr(6'h18, 8'h10);
    n0 = nx;
    cmd_st(8'h20, 8'h40);
    check("start", nx - n0, 0);
    $display("-- diagnostic done");
    conclude();
  end
endmodule // tb_acd_dispatch
`default_nettype wire
